// File: core/aie_map.vh
// Purpose: Constants for the accumulator and port instruction executor
// Assumes: Included by bare name from the core files
// Notes:   Opcode values are the encoding this core decodes
`ifndef AIE_MAP_VH
`define AIE_MAP_VH

// Machine cycle length in device clocks
`define AIE_CYC_CLKS 15
`define AIE_PH_W 4

// Reset values
`define AIE_RST_ACC 8'h00
`define AIE_RST_PORT 8'hFF
`define AIE_RST_PC 11'h000
`define AIE_RST_STATUS 4'h0

// Full opcodes
`define AIE_OP_ROT_LEFT_CY 8'hF7
`define AIE_OP_IN_HOST 8'h22
`define AIE_OP_OUT_HOST 8'h02
`define AIE_OP_MOV_STATUS 8'h90
`define AIE_OP_AND_P1 8'h99
`define AIE_OP_AND_P2 8'h9A
`define AIE_OP_OR_P1 8'h89
`define AIE_OP_OR_P2 8'h8A

// Opcode groups on bits 7:3, register number in bits 2:0
`define AIE_GRP_ADD_CY 5'h0D
`define AIE_GRP_MOV_R 5'h15

// Expander groups on bits 7:2, expander port in bits 1:0
`define AIE_EXG_READ 6'h03
`define AIE_EXG_WRITE 6'h0F
`define AIE_EXG_AND 6'h27
`define AIE_EXG_OR 6'h23

// Expander control codes sent on the first nibble
`define AIE_EXC_READ 2'h0
`define AIE_EXC_WRITE 2'h1
`define AIE_EXC_OR 2'h2
`define AIE_EXC_AND 2'h3

// Arithmetic unit operations
`define AIE_ALU_ADD_CY 3'h0
`define AIE_ALU_ROTATE 3'h1
`define AIE_ALU_AND 3'h2
`define AIE_ALU_OR 3'h3
`define AIE_ALU_PASS 3'h4

`endif

// File: core/aie_alu.v
// Purpose: Accumulator arithmetic and logic unit
// Assumes: Purely combinational, used by the executor
// Notes:   Carry out only meaningful for add and rotate
`timescale 1ns/100ps
`include "aie_map.vh"

module aie_alu (
  input wire [2:0] i_op,
  input wire [7:0] i_a,
  input wire [7:0] i_b,
  input wire i_carry,
  output reg [7:0] o_result,
  output reg o_carry
);

  // Nine-bit sum keeps the carry out
  wire [8:0] sum;
  assign sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_carry};

  // Operation select
  always @* begin
    o_result = i_b;
    o_carry = i_carry;
    case (i_op)
      `AIE_ALU_ADD_CY: begin
        o_result = sum[7:0];
        o_carry = sum[8];
      end
      `AIE_ALU_ROTATE: begin
        o_result = {i_a[6:0], i_carry}; // Old carry into bit 0
        o_carry = i_a[7];
      end
      `AIE_ALU_AND: o_result = i_a & i_b;
      `AIE_ALU_OR: o_result = i_a | i_b;
      default: o_result = i_b;
    endcase
  end

endmodule // aie_alu

// File: core/aie_exec.v
// Purpose: Executes accumulator, port and expander instructions
// Assumes: Fetch logic and host side run on i_clk
// Notes:   One machine cycle is CYC_CLKS device clocks
// Contract
// - Add register plus carry into accumulator, one byte, one machine cycle.
// - Rotate accumulator left through carry, old carry into bit 0, one cycle.
// - AND immediate byte into port latch, two bytes, two machine cycles.
// - OR immediate byte into port latch, two bytes, two machine cycles.
// - Read expander port into accumulator, one byte, two machine cycles.
// - AND accumulator into expander port, one byte, two machine cycles.
// - In external access mode, port data valid at sync rising edge.
// - In external access mode, program counter on port at sync falling edge.
`timescale 1ns/100ps
`include "aie_map.vh"

module aie_exec #(
  parameter CYC_CLKS = `AIE_CYC_CLKS,
  parameter PH_W = `AIE_PH_W
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_external_access_mode,
  input wire [7:0] i_fetch_data,
  output wire o_fetch_req,
  output reg [10:0] o_pc,
  output reg o_sync,
  output reg [7:0] o_p1,
  output reg [7:0] o_p2,
  output reg [3:0] o_p2_lo_oe,
  input wire [3:0] i_p2_lo,
  output reg o_prog_n,
  input wire i_host_wr,
  input wire [7:0] i_host_wr_data,
  input wire i_host_rd,
  output reg [7:0] o_host_buffer,
  output wire [7:0] o_host_status_reg,
  output reg [7:0] o_acc,
  output reg o_carry
);

  localparam S_FETCH = 1'b0;
  localparam S_SECOND = 1'b1;
  localparam [PH_W-1:0] PH_LAST = CYC_CLKS - 1;
  localparam [PH_W-1:0] PH_HALF = CYC_CLKS / 2;

  reg [PH_W-1:0] ph_q;
  reg st_q;
  reg [7:0] op_q;
  reg [7:0] p1_q;
  reg [7:0] p2_q;
  reg [7:0] host_in_q;
  reg input_full_flag_q;
  reg output_full_flag_q;
  reg [3:0] status_hi_q;
  reg [7:0] wreg_q [0:7];
  reg ext_s1_q;
  reg ext_s2_q;
  reg [3:0] p2_s1_q;
  reg [3:0] p2_s2_q;
  reg [PH_W-1:0] ph_d;
  integer i;

  wire last_ph;
  wire [7:0] opc;
  wire is_add_cy;
  wire is_movr;
  wire is_port_imm;
  wire is_exp;
  wire two_cyc;
  wire [1:0] exp_ctl;
  reg [2:0] alu_op;
  reg [7:0] alu_a;
  reg [7:0] alu_b;
  wire [7:0] alu_res;
  wire alu_cy;

  // Machine cycle phase
  assign last_ph = (ph_q == PH_LAST);
  always @* begin
    ph_d = last_ph ? {PH_W{1'b0}} : ph_q + 1'b1;
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ph_q <= {PH_W{1'b0}};
    end else begin
      ph_q <= ph_d;
    end
  end

  // Pin synchronisers
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      p2_s1_q <= 4'h0;
      p2_s2_q <= 4'h0;
    end else begin
      ext_s1_q <= i_external_access_mode;
      ext_s2_q <= ext_s1_q;
      p2_s1_q <= i_p2_lo;
      p2_s2_q <= p2_s1_q;
    end
  end

  // Decode, opcode from fetch bus in first cycle
  assign opc = (st_q == S_FETCH) ? i_fetch_data : op_q;
  assign is_add_cy = (opc[7:3] == `AIE_GRP_ADD_CY);
  assign is_movr = (opc[7:3] == `AIE_GRP_MOV_R);
  assign is_port_imm = (opc == `AIE_OP_AND_P1) || (opc == `AIE_OP_AND_P2) ||
                       (opc == `AIE_OP_OR_P1) || (opc == `AIE_OP_OR_P2);
  assign is_exp = (opc[7:2] == `AIE_EXG_READ) || (opc[7:2] == `AIE_EXG_WRITE) ||
                  (opc[7:2] == `AIE_EXG_AND) || (opc[7:2] == `AIE_EXG_OR);
  assign two_cyc = is_port_imm | is_exp;
  assign exp_ctl = (opc[7:2] == `AIE_EXG_READ) ? `AIE_EXC_READ :
                   (opc[7:2] == `AIE_EXG_WRITE) ? `AIE_EXC_WRITE :
                   (opc[7:2] == `AIE_EXG_AND) ? `AIE_EXC_AND : `AIE_EXC_OR;

  // Byte request at each machine cycle end that consumes a byte
  assign o_fetch_req = last_ph & ((st_q == S_FETCH) | is_port_imm);

  // Operand steering for the arithmetic unit
  always @* begin
    alu_op = `AIE_ALU_PASS;
    alu_a = o_acc;
    alu_b = wreg_q[opc[2:0]];
    if (is_add_cy) begin
      alu_op = `AIE_ALU_ADD_CY;
    end else if (opc == `AIE_OP_ROT_LEFT_CY) begin
      alu_op = `AIE_ALU_ROTATE;
    end else if (is_port_imm) begin
      alu_op = opc[4] ? `AIE_ALU_AND : `AIE_ALU_OR;
      alu_a = opc[0] ? p1_q : p2_q;
      alu_b = i_fetch_data;
    end
  end

  aie_alu u_alu (
    .i_op(alu_op),
    .i_a(alu_a),
    .i_b(alu_b),
    .i_carry(o_carry),
    .o_result(alu_res),
    .o_carry(alu_cy)
  );

  // Sequencer and execution at machine cycle end
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= S_FETCH;
      op_q <= 8'h00;
      o_pc <= `AIE_RST_PC;
      o_acc <= `AIE_RST_ACC;
      o_carry <= 1'b0;
      p1_q <= `AIE_RST_PORT;
      p2_q <= `AIE_RST_PORT;
      status_hi_q <= `AIE_RST_STATUS;
      o_host_buffer <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        wreg_q[i] <= 8'h00;
      end
    end else if (last_ph) begin
      if (o_fetch_req) begin
        o_pc <= o_pc + 11'h001;
      end
      if (st_q == S_FETCH) begin
        op_q <= i_fetch_data;
        if (two_cyc) begin
          st_q <= S_SECOND;
        end else if (is_add_cy || opc == `AIE_OP_ROT_LEFT_CY) begin
          o_acc <= alu_res;
          o_carry <= alu_cy;
        end else if (is_movr) begin
          wreg_q[opc[2:0]] <= o_acc;
        end else if (opc == `AIE_OP_IN_HOST) begin
          o_acc <= host_in_q;
        end else if (opc == `AIE_OP_OUT_HOST) begin
          o_host_buffer <= o_acc;
        end else if (opc == `AIE_OP_MOV_STATUS) begin
          status_hi_q <= o_acc[7:4];
        end
      end else begin
        st_q <= S_FETCH;
        if (is_port_imm && opc[0]) begin
          p1_q <= alu_res;
        end else if (is_port_imm) begin
          p2_q <= alu_res;
        end else if (exp_ctl == `AIE_EXC_READ) begin
          o_acc <= {4'h0, p2_s2_q};
        end
      end
    end
  end

  // Host flags, a set wins over a clear in the same cycle
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      host_in_q <= 8'h00;
      input_full_flag_q <= 1'b0;
      output_full_flag_q <= 1'b0;
    end else begin
      if (i_host_wr) begin
        host_in_q <= i_host_wr_data;
        input_full_flag_q <= 1'b1;
      end else if (last_ph && st_q == S_FETCH && opc == `AIE_OP_IN_HOST) begin
        input_full_flag_q <= 1'b0;
      end
      if (last_ph && st_q == S_FETCH && opc == `AIE_OP_OUT_HOST) begin
        output_full_flag_q <= 1'b1;
      end else if (i_host_rd) begin
        output_full_flag_q <= 1'b0;
      end
    end
  end

  // Status: accumulator-loaded high nibble, flags in bits 1:0
  assign o_host_status_reg = {status_hi_q, 2'b00, input_full_flag_q, output_full_flag_q};

  // Sync and port 1, data from the sync rise, counter from the sync fall, on the same edges
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sync <= 1'b0;
      o_p1 <= `AIE_RST_PORT;
    end else begin
      o_sync <= (ph_d < PH_HALF);
      if (ext_s2_q && ph_d >= PH_HALF) begin
        o_p1 <= o_pc[7:0];
      end else begin
        o_p1 <= p1_q;
      end
    end
  end

  // Port 2 and expander strobe during the second machine cycle
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_p2 <= `AIE_RST_PORT;
      o_p2_lo_oe <= 4'hF;
      o_prog_n <= 1'b1;
    end else if (st_q == S_SECOND && is_exp && !last_ph) begin
      o_p2[7:4] <= p2_q[7:4];
      if (ph_d < PH_HALF) begin
        o_p2[3:0] <= {exp_ctl, opc[1:0]}; // Command and port number
        o_p2_lo_oe <= 4'hF;
        o_prog_n <= 1'b1;
      end else begin
        o_p2[3:0] <= o_acc[3:0];
        o_p2_lo_oe <= (exp_ctl == `AIE_EXC_READ) ? 4'h0 : 4'hF;
        o_prog_n <= 1'b0;
      end
    end else begin
      o_p2 <= p2_q;
      o_p2_lo_oe <= 4'hF;
      o_prog_n <= 1'b1;
    end
  end

endmodule // aie_exec

// File: core/aie_alu_end.v
`timescale 1ns/100ps

// File: bench/aie_ext_model.sv
// Purpose: Port 2 expander and pull-up model
// Assumes: Answers reads while the strobe is low
// Notes: Released lines float high
`timescale 1ns/100ps
module aie_ext_model (
  input wire i_prog_n,
  input wire [3:0] i_oe,
  input wire [3:0] i_dev,
  input wire [3:0] i_rd_nib,
  output wire [3:0] o_p2_lo
);
  // Device bits, else read nibble under strobe, else pull-up
  assign o_p2_lo = (i_oe & i_dev) | (~i_oe & (i_prog_n ? 4'hF : i_rd_nib));
endmodule // aie_ext_model

// File: bench/aie_exec_assertions.sv
// Purpose: Port timing and result checks
// Assumes: One clock, async active-low reset
// Notes: Bound into aie_exec below
`timescale 1ns/100ps
`include "aie_map.vh"
module aie_exec_chk #(
  parameter int CYC_CLKS = 15,
  parameter int PH_W = 4
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_external_access_mode,
  input wire [7:0] i_fetch_data,
  input wire i_host_wr,
  input wire o_fetch_req,
  input wire [10:0] o_pc,
  input wire o_sync,
  input wire [7:0] o_p1,
  input wire o_prog_n,
  input wire [7:0] o_host_status_reg,
  input wire [7:0] o_acc,
  input wire o_carry
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Marks the byte after a port immediate opcode
  logic imm_q;
  wire take = o_fetch_req && !imm_q;
  wire imm_op = i_fetch_data[7:5] == 3'h4 && i_fetch_data[3:2] == 2'h2 && ^i_fetch_data[1:0];
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) imm_q <= 1'b0;
    else if (o_fetch_req) imm_q <= !imm_q && imm_op;
  end
  a_sync_low_len: assert property ($fell(o_sync) |-> !o_sync [*8] ##1 o_sync)
    else $error("sync low span");
  a_pc_on_port: assert property ($fell(o_sync) && i_external_access_mode
    && $past(i_external_access_mode, 3) |-> o_p1 == o_pc[7:0]) else $error("pc not on port");
  a_prog_at_sync: assert property ($fell(o_prog_n) |-> $fell(o_sync))
    else $error("strobe misplaced");
  a_rotate_result: assert property (take && i_fetch_data == `AIE_OP_ROT_LEFT_CY
    |=> {o_carry, o_acc} == {$past(o_acc), $past(o_carry)}) else $error("rotate wrong");
  a_exp_two_cyc: assert property (take && (i_fetch_data[7:2] == `AIE_EXG_READ
    || i_fetch_data[7:2] == `AIE_EXG_AND) |-> ##CYC_CLKS !o_fetch_req ##CYC_CLKS o_fetch_req)
    else $error("expander op length");
  // Port pins follow the latch one clock after the immediate is taken
  a_or_port1: assert property (take && i_fetch_data == `AIE_OP_OR_P1
    |-> ##CYC_CLKS o_fetch_req && $stable(o_p1) ##2
    o_p1 == ($past(o_p1, 2) | $past(i_fetch_data, 2))) else $error("port or wrong");
  a_in_clears: assert property (take && i_fetch_data == `AIE_OP_IN_HOST && !i_host_wr
    |=> !o_host_status_reg[1]) else $error("input full kept");
  a_status_copy: assert property (take && i_fetch_data == `AIE_OP_MOV_STATUS
    |=> o_host_status_reg[7:4] == $past(o_acc) >> 4) else $error("status copy wrong");
  // Main scenarios reached
  c_rotate: cover property (take && i_fetch_data == `AIE_OP_ROT_LEFT_CY);
  c_read: cover property (take && i_fetch_data[7:2] == `AIE_EXG_READ);
  c_pc_port: cover property ($fell(o_sync) && i_external_access_mode);
endmodule // aie_exec_chk
bind aie_exec aie_exec_chk #(.CYC_CLKS(CYC_CLKS), .PH_W(PH_W)) aie_exec_chk_i (.i_clk,
  .i_reset_n, .i_external_access_mode, .i_fetch_data, .i_host_wr, .o_fetch_req, .o_pc,
  .o_sync, .o_p1, .o_prog_n, .o_host_status_reg, .o_acc, .o_carry);

// File: bench/tb.sv
// Purpose: Self-checking bench for aie_exec
// Assumes: Byte source holds each byte until the next step drives another
// Notes: Fixed seed, corner values in round 0
`timescale 1ns/100ps
`include "aie_map.vh"
module tb;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_external_access_mode = 1'b0, c = 1'b0;
  logic i_host_wr = 1'b0, i_host_rd = 1'b0;
  logic [7:0] i_fetch_data = 8'h00, i_host_wr_data = 8'h00, p1 = 8'hFF, p2 = 8'hFF;
  logic [7:0] o_p1, o_p2, o_host_buffer, o_host_status_reg, o_acc, a, v, o;
  logic [7:0] r [8];
  logic [10:0] o_pc;
  logic [10:0] npc = 11'h000;
  logic [3:0] o_p2_lo_oe, i_p2_lo;
  logic [3:0] nib = 4'h0;
  logic [2:0] rn;
  logic [1:0] pp, xc;
  logic [5:0] xg;
  logic o_fetch_req, o_sync, o_prog_n, o_carry;
  int n_fail = 0, total_checks = 0, k;
  // Design and port 2 expander
  aie_exec aie_exec_i (.i_clk, .i_reset_n, .i_external_access_mode, .i_fetch_data, .o_fetch_req,
    .o_pc, .o_sync, .o_p1, .o_p2, .o_p2_lo_oe, .i_p2_lo, .o_prog_n, .i_host_wr, .i_host_wr_data,
    .i_host_rd, .o_host_buffer, .o_host_status_reg, .o_acc, .o_carry);
  aie_ext_model aie_ext_model_i (.i_prog_n(o_prog_n), .i_oe(o_p2_lo_oe), .i_dev(o_p2[3:0]),
    .i_rd_nib(nib), .o_p2_lo(i_p2_lo));
  // Clock and count of bytes taken
  initial forever #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_fetch_req === 1'b1) npc <= npc + 11'h001;
  function automatic logic [8:0] f_add_cy(input logic [7:0] x, y, input logic ci);
    return x + y + ci;
  endfunction
  function automatic logic [7:0] f_port(input logic [7:0] op, old, imm);
    return op[4] ? (old & imm) : (old | imm);
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task cyc(input int m);
    repeat (m) @(posedge i_clk);
    #1;
  endtask
  task step(input logic [7:0] b);
    i_fetch_data = b;
    // Byte left standing, so back-to-back steps each feed one fetch request
    while (o_fetch_req !== 1'b1) cyc(1);
    cyc(1);
  endtask
  task load(input logic [7:0] d);
    i_host_wr_data = d;
    i_host_wr = 1'b1;
    cyc(1);
    i_host_wr = 1'b0;
    chk(o_host_status_reg & 8'h02, 8'h02);
    step(`AIE_OP_IN_HOST);
    a = d;
    chk(o_host_status_reg & 8'h02, 8'h00);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    k = $urandom(32'hE0CF7690);
    cyc(16);
    i_reset_n = 1'b1;
    chk(o_acc, 8'h00);
    chk(o_p1 & o_p2, 8'hFF);
    for (k = 0; k < 12; k++) begin
      rn = 3'($urandom);
      pp = 2'($urandom);
      nib = 4'($urandom);
      load(k == 0 ? 8'hFF : 8'($urandom));
      step({`AIE_GRP_MOV_R, rn});
      r[rn] = a;
      load(k == 0 ? 8'h01 : 8'($urandom));
      step({`AIE_GRP_ADD_CY, rn});
      {c, a} = f_add_cy(a, r[rn], c);
      chk(o_acc, a);
      chk({7'h0, o_carry}, {7'h0, c});
      step(`AIE_OP_ROT_LEFT_CY);
      {c, a} = {a, c};
      chk({7'h0, o_carry}, {7'h0, c});
      step(`AIE_OP_OUT_HOST);
      chk(o_host_buffer, a);
      chk(o_host_status_reg & 8'h01, 8'h01);
      i_host_rd = 1'b1;
      cyc(1);
      i_host_rd = 1'b0;
      step(`AIE_OP_MOV_STATUS);
      chk(o_host_status_reg, a & 8'hF0);
      o = {3'h4, k[0], 2'h2, k[1], ~k[1]};
      v = 8'($urandom);
      step(o);
      step(v);
      if (o[0]) p1 = f_port(o, p1, v);
      else p2 = f_port(o, p2, v);
      // Port pins show the new latch one clock after the immediate
      cyc(1);
      chk(o_p1, p1);
      chk(o_p2, p2);
      step({`AIE_EXG_READ, pp});
      step(8'h00);
      a = {4'h0, nib};
      chk(o_acc, a);
      // Expander AND, OR and write in turn
      xg = (k % 3 == 0) ? `AIE_EXG_AND : (k % 3 == 1) ? `AIE_EXG_OR : `AIE_EXG_WRITE;
      xc = (k % 3 == 0) ? `AIE_EXC_AND : (k % 3 == 1) ? `AIE_EXC_OR : `AIE_EXC_WRITE;
      step({xg, pp});
      cyc(3);
      chk({4'h0, o_p2[3:0]}, {4'h0, xc, pp});
      cyc(6);
      chk({o_prog_n, 3'h0, o_p2[3:0]}, {4'h0, a[3:0]});
      $display("round %0d done", k);
    end
    i_external_access_mode = 1'b1;
    i_fetch_data = 8'h00;
    cyc(3);
    while (o_sync !== 1'b1) cyc(1);
    while (o_sync !== 1'b0) cyc(1);
    chk(o_p1, npc[7:0]);
    while (o_sync !== 1'b1) cyc(1);
    chk(o_p1, p1);
    i_external_access_mode = 1'b0;
    $display("port strobe test done");
    cyc(40);
    end_of_test();
  end
  // Watchdog
  initial begin
    #100000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule // tb
